// [hdl/supervisor_cfg_pkg.sv]
// Constants, field layouts and types for the channel 7 and 8 supervisor configuration bank.
//
// How it works
// - With 1x scaling a threshold code means 0.2 V plus 5 mV per step.
// - With 4x scaling a threshold code means 0.8 V plus 20 mV per step.
// - The range multiplier input picks which scaling every threshold code uses.
// - Each channel holds fast and slow undervoltage and overvoltage 8-bit thresholds.
// - Overvoltage thresholds leave reset at all ones.
// - Undervoltage thresholds leave reset at zero.
// - A fast fault changes only after its comparator stays stable for the debounce time.
// - Debounce code n gives 0.1 us doubled n times, capped at 102.4 us.
// - Cutoff codes 2 to 6 select 250 Hz, 500 Hz, 1 kHz, 2 kHz, 4 kHz.
// - The cutoff field leaves reset selecting 1 kHz.
// - The cutoff code retunes the slow path low-pass filter corner.
// - The cutoff register resets to 0x14 and its bits 7 to 3 are read-only.
// - Writing one to the self-test bit starts built-in self-test.
// - The manual reset bit asserts the reset output while it is one.
// - The self-test and reset control register resets to 0x02.
// - The reset delay field picks 200 us up to 200 ms; default is 10 ms.
package supervisor_cfg_pkg;

  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned CLK_MHZ       = 50;
  localparam int unsigned CLK_PERIOD_NS = 20;

  localparam logic [7:0] ADDR_CH7_FAST_UNDER = 8'h80;
  localparam logic [7:0] ADDR_CH7_FAST_OVER  = 8'h81;
  localparam logic [7:0] ADDR_CH7_SLOW_UNDER = 8'h82;
  localparam logic [7:0] ADDR_CH7_SLOW_OVER  = 8'h83;
  localparam logic [7:0] ADDR_CH7_DEBOUNCE   = 8'h84;
  localparam logic [7:0] ADDR_CH7_CUTOFF     = 8'h85;
  localparam logic [7:0] ADDR_CH8_FAST_UNDER = 8'h90;
  localparam logic [7:0] ADDR_CH8_FAST_OVER  = 8'h91;
  localparam logic [7:0] ADDR_CH8_SLOW_UNDER = 8'h92;
  localparam logic [7:0] ADDR_CH8_SLOW_OVER  = 8'h93;
  localparam logic [7:0] ADDR_CH8_DEBOUNCE   = 8'h94;
  localparam logic [7:0] ADDR_CH8_CUTOFF     = 8'h95;
  localparam logic [7:0] ADDR_CONTROL        = 8'h9F;

  localparam logic [7:0] UNDER_RESET    = 8'h00;
  localparam logic [7:0] OVER_RESET     = 8'hFF;
  localparam logic [7:0] DEBOUNCE_RESET = 8'h00;
  localparam logic [7:0] CUTOFF_RESET   = 8'h14;
  localparam logic [7:0] CONTROL_RESET  = 8'h02;
  localparam logic [7:0] CUTOFF_WMASK   = 8'h07;
  localparam logic [7:0] CONTROL_WMASK  = 8'hE7;
  localparam logic [7:0] UNMAPPED_READ  = 8'h00;

  localparam int unsigned DEB_OVER_LSB  = 4;
  localparam int unsigned DEB_UNDER_LSB = 0;
  localparam int unsigned CTRL_SELFTEST = 7;
  localparam int unsigned CTRL_MANRST   = 5;
  localparam int unsigned CTRL_DELAY_LSB = 0;

  localparam int unsigned  MV_W         = 13;
  localparam logic [12:0]  BASE_1X_MV   = 13'h00C8;
  localparam logic [12:0]  STEP_1X_MV   = 13'h0005;
  localparam logic [12:0]  BASE_4X_MV   = 13'h0320;
  localparam logic [12:0]  STEP_4X_MV   = 13'h0014;

  localparam int unsigned DEB_BASE_NS       = 100;
  localparam int unsigned DEB_BASE_CYCLES   = (DEB_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  DEB_CODE_CAP      = 4'hA;
  localparam int unsigned DEB_LONGEST_CYCLES = DEB_BASE_CYCLES << DEB_CODE_CAP;
  localparam int unsigned DEB_CNT_W         = 13;

  localparam logic [2:0] CUT_250HZ = 3'h2;
  localparam logic [2:0] CUT_1KHZ  = 3'h4;
  localparam logic [2:0] CUT_4KHZ  = 3'h6;
  localparam logic [2:0] LPF_SHIFT_BASE = 3'h0;
  localparam int unsigned LPF_FRAC     = 8;
  localparam int unsigned LPF_RATE_HZ  = 100_531;
  localparam int unsigned LPF_TICK_CYCLES = CLK_HZ / LPF_RATE_HZ;
  localparam int unsigned TICK_W       = 9;

  localparam int unsigned RST_DELAY_US [8] = '{200, 1000, 10000, 16000, 20000, 70000, 100000, 200000};
  localparam int unsigned RST_DELAY_CYCLES [8] = '{RST_DELAY_US[0] * CLK_MHZ, RST_DELAY_US[1] * CLK_MHZ,
    RST_DELAY_US[2] * CLK_MHZ, RST_DELAY_US[3] * CLK_MHZ, RST_DELAY_US[4] * CLK_MHZ,
    RST_DELAY_US[5] * CLK_MHZ, RST_DELAY_US[6] * CLK_MHZ, RST_DELAY_US[7] * CLK_MHZ};
  localparam int unsigned RST_CNT_W = 24;

  typedef enum logic [2:0] {
    SEL_FAST_UNDER = 3'h0,
    SEL_FAST_OVER  = 3'h1,
    SEL_SLOW_UNDER = 3'h2,
    SEL_SLOW_OVER  = 3'h3,
    SEL_DEBOUNCE   = 3'h4,
    SEL_CUTOFF     = 3'h5,
    SEL_CONTROL    = 3'h6
  } reg_sel_t;

  typedef struct packed {
    logic     hit;
    logic     ch;
    reg_sel_t sel;
  } reg_slot_t;

  typedef enum logic [2:0] {
    RST_IDLE  = 3'h1,
    RST_HELD  = 3'h2,
    RST_DELAY = 3'h4
  } rst_state_t;

endpackage : supervisor_cfg_pkg

// [hdl/fast_fault_debounce.sv]
// Debounce filter that passes a comparator level only after it holds for the programmed time.
module fast_fault_debounce
  import supervisor_cfg_pkg::*;
#(
  parameter int unsigned UNIT_CYCLES = DEB_BASE_CYCLES
)
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  // Comparator and setting
  input  wire logic       raw,
  input  wire logic [3:0] code,
  // Debounced fault
  output logic            filtered
);

  typedef struct packed {
    logic                 level;
    logic [DEB_CNT_W-1:0] count;
  } deb_state_t;

  deb_state_t           st;
  deb_state_t           next_st;
  logic [DEB_CNT_W-1:0] target;

  // Codes above the cap all give the longest time, so software cannot overflow the counter.
  function automatic logic [DEB_CNT_W-1:0] hold_cycles(input logic [3:0] c);
    logic [3:0] s;
    s = (c > DEB_CODE_CAP) ? DEB_CODE_CAP : c;
    return DEB_CNT_W'(UNIT_CYCLES << s);
  endfunction : hold_cycles

  assign target   = hold_cycles(code);
  assign filtered = st.level;

  always_comb
  begin
    next_st = st;
    if (raw == st.level)
    begin
      next_st.count = '0;
    end
    else if (st.count >= target - DEB_CNT_W'(1))
    begin
      next_st.level = raw;
      next_st.count = '0;
    end
    else
    begin
      next_st.count = st.count + DEB_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // A shortened debounce time ends a longer count at once, so the edge after a code change is left out.
  debounce_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $changed(st.level) && $past(target) == $past(target, 2) |-> $past(st.count) == $past(target) - DEB_CNT_W'(1))
    else $error("Fault level changed before the debounce time ran out.");

  debounce_reset_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (raw == st.level) |=> (st.count == '0) && $stable(st.level))
    else $error("Debounce count not cleared when the comparator matched.");

endmodule : fast_fault_debounce

// [hdl/slow_path_lowpass.sv]
// First-order low-pass filter whose corner follows the slow path cutoff code.
module slow_path_lowpass
  import supervisor_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic            clk_sys,
  input  wire logic            arst_n,
  // Sample stream
  input  wire logic            tick,
  input  wire logic [MV_W-1:0] sample,
  input  wire logic [2:0]      cutoff,
  // Filtered level
  output logic      [MV_W-1:0] level
);

  localparam int unsigned ACC_W = MV_W + LPF_FRAC;

  typedef struct packed {
    logic [ACC_W-1:0] acc;
  } lpf_state_t;

  lpf_state_t              st;
  lpf_state_t              next_st;
  logic [2:0]              code;
  logic [2:0]              shift;
  logic signed [ACC_W:0]   diff;
  logic signed [ACC_W:0]   step;

  // Doubling the corner lowers the shift by one, so one update rate covers every corner.
  // An invalid code falls back to the reset corner rather than leaving the filter untuned.
  assign code  = (cutoff < CUT_250HZ || cutoff > CUT_4KHZ) ? CUT_1KHZ : cutoff;
  assign shift = 3'(LPF_SHIFT_BASE - code);
  assign diff  = $signed({1'b0, sample, LPF_FRAC'(0)}) - $signed({1'b0, st.acc});
  assign step  = diff >>> shift;
  assign level = st.acc[ACC_W-1:LPF_FRAC];

  always_comb
  begin
    next_st = st;
    if (tick)
    begin
      next_st.acc = ACC_W'($signed({1'b0, st.acc}) + step);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  lowpass_idle_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !tick |=> $stable(st.acc))
    else $error("Slow path filter moved without an update tick.");

endmodule : slow_path_lowpass

// [hdl/supervisor_channel_config_regs.sv]
// Register bank, threshold comparators and reset control for supervisor channels 7 and 8.
module supervisor_channel_config_regs
  import supervisor_cfg_pkg::*;
#(
  parameter int unsigned DEBOUNCE_LONGEST_CYCLES = DEB_LONGEST_CYCLES,
  parameter int unsigned RESET_DELAY_CYCLES [8]  = RST_DELAY_CYCLES
)
(
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 arst_n,
  // Register port
  input  wire logic                 reg_write,
  input  wire logic                 reg_read,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  output logic      [7:0]           reg_rdata,
  // Scaling, one bit per channel, high for 4x
  input  wire logic [1:0]           range_multiplier,
  // Measured voltages in millivolts
  input  wire logic [1:0][MV_W-1:0] fast_sample_mv,
  input  wire logic [1:0][MV_W-1:0] slow_sample_mv,
  // Faults
  output logic      [1:0]           fast_over_fault,
  output logic      [1:0]           fast_under_fault,
  output logic      [1:0]           slow_over_fault,
  output logic      [1:0]           slow_under_fault,
  // Analog filter setting and system control
  output logic      [1:0][2:0]      slow_cutoff_code,
  output logic                      selftest_start,
  output logic                      reset_out_n
);

  typedef struct packed {
    logic [1:0][7:0]       fast_under;
    logic [1:0][7:0]       fast_over;
    logic [1:0][7:0]       slow_under;
    logic [1:0][7:0]       slow_over;
    logic [1:0][7:0]       debounce;
    logic [1:0][7:0]       cutoff;
    logic [7:0]            control;
    logic [7:0]            rdata;
    logic [1:0]            fast_over_raw;
    logic [1:0]            fast_under_raw;
    logic [1:0]            slow_over_flag;
    logic [1:0]            slow_under_flag;
    logic [1:0][2:0]       cutoff_out;
    logic                  selftest_pulse;
    rst_state_t            rst_state;
    logic                  rst_out_n;
    logic [RST_CNT_W-1:0]  delay_cnt;
    logic [TICK_W-1:0]     tick_cnt;
    logic                  lpf_tick;
  } bank_state_t;

  bank_state_t          st;
  bank_state_t          next_st;
  reg_slot_t            wr_slot;
  reg_slot_t            rd_slot;
  logic [1:0][MV_W-1:0] slow_level;
  logic [1:0]           fast_over_db;
  logic [1:0]           fast_under_db;

  function automatic reg_slot_t decode(input logic [7:0] a);
    reg_slot_t s;
    s = '{hit: 1'b1, ch: 1'b0, sel: SEL_CONTROL};
    case (a)
      ADDR_CH7_FAST_UNDER: s = '{hit: 1'b1, ch: 1'b0, sel: SEL_FAST_UNDER};
      ADDR_CH7_FAST_OVER:  s = '{hit: 1'b1, ch: 1'b0, sel: SEL_FAST_OVER};
      ADDR_CH7_SLOW_UNDER: s = '{hit: 1'b1, ch: 1'b0, sel: SEL_SLOW_UNDER};
      ADDR_CH7_SLOW_OVER:  s = '{hit: 1'b1, ch: 1'b0, sel: SEL_SLOW_OVER};
      ADDR_CH7_DEBOUNCE:   s = '{hit: 1'b1, ch: 1'b0, sel: SEL_DEBOUNCE};
      ADDR_CH7_CUTOFF:     s = '{hit: 1'b1, ch: 1'b0, sel: SEL_CUTOFF};
      ADDR_CH8_FAST_UNDER: s = '{hit: 1'b1, ch: 1'b1, sel: SEL_FAST_UNDER};
      ADDR_CH8_FAST_OVER:  s = '{hit: 1'b1, ch: 1'b1, sel: SEL_FAST_OVER};
      ADDR_CH8_SLOW_UNDER: s = '{hit: 1'b1, ch: 1'b1, sel: SEL_SLOW_UNDER};
      ADDR_CH8_SLOW_OVER:  s = '{hit: 1'b1, ch: 1'b1, sel: SEL_SLOW_OVER};
      ADDR_CH8_DEBOUNCE:   s = '{hit: 1'b1, ch: 1'b1, sel: SEL_DEBOUNCE};
      ADDR_CH8_CUTOFF:     s = '{hit: 1'b1, ch: 1'b1, sel: SEL_CUTOFF};
      ADDR_CONTROL:        s = '{hit: 1'b1, ch: 1'b0, sel: SEL_CONTROL};
      default:             s = '{hit: 1'b0, ch: 1'b0, sel: SEL_CONTROL};
    endcase
    return s;
  endfunction : decode

  // The code widens before the multiply so the top code in 4x scaling does not wrap.
  function automatic logic [MV_W-1:0] limit_mv(input logic [7:0] code, input logic mult);
    logic [MV_W-1:0] wide;
    wide = MV_W'(code);
    if (mult)
    begin
      return MV_W'(BASE_4X_MV + wide * STEP_4X_MV);
    end
    return MV_W'(BASE_1X_MV + wide * STEP_1X_MV);
  endfunction : limit_mv

  assign wr_slot = decode(reg_addr);
  assign rd_slot = decode(reg_addr);

  always_comb
  begin
    next_st                = st;
    next_st.selftest_pulse = 1'b0;
    next_st.lpf_tick       = 1'b0;

    if (reg_write && wr_slot.hit)
    begin
      case (wr_slot.sel)
        SEL_FAST_UNDER: next_st.fast_under[wr_slot.ch] = reg_wdata;
        SEL_FAST_OVER:  next_st.fast_over[wr_slot.ch]  = reg_wdata;
        SEL_SLOW_UNDER: next_st.slow_under[wr_slot.ch] = reg_wdata;
        SEL_SLOW_OVER:  next_st.slow_over[wr_slot.ch]  = reg_wdata;
        SEL_DEBOUNCE:   next_st.debounce[wr_slot.ch]   = reg_wdata;
        SEL_CUTOFF:
        begin
          next_st.cutoff[wr_slot.ch] = (st.cutoff[wr_slot.ch] & ~CUTOFF_WMASK) | (reg_wdata & CUTOFF_WMASK);
        end
        SEL_CONTROL:
        begin
          next_st.control        = (st.control & ~CONTROL_WMASK) | (reg_wdata & CONTROL_WMASK);
          next_st.selftest_pulse = reg_wdata[CTRL_SELFTEST];
        end
        default:        next_st.control = st.control;
      endcase
    end

    if (reg_read)
    begin
      next_st.rdata = UNMAPPED_READ;
      if (rd_slot.hit)
      begin
        case (rd_slot.sel)
          SEL_FAST_UNDER: next_st.rdata = st.fast_under[rd_slot.ch];
          SEL_FAST_OVER:  next_st.rdata = st.fast_over[rd_slot.ch];
          SEL_SLOW_UNDER: next_st.rdata = st.slow_under[rd_slot.ch];
          SEL_SLOW_OVER:  next_st.rdata = st.slow_over[rd_slot.ch];
          SEL_DEBOUNCE:   next_st.rdata = st.debounce[rd_slot.ch];
          SEL_CUTOFF:     next_st.rdata = st.cutoff[rd_slot.ch];
          SEL_CONTROL:    next_st.rdata = st.control;
          default:        next_st.rdata = UNMAPPED_READ;
        endcase
      end
    end

    for (int c = 0; c < 2; c++)
    begin
      next_st.fast_over_raw[c]   = fast_sample_mv[c] > limit_mv(st.fast_over[c], range_multiplier[c]);
      next_st.fast_under_raw[c]  = fast_sample_mv[c] < limit_mv(st.fast_under[c], range_multiplier[c]);
      next_st.slow_over_flag[c]  = slow_level[c] > limit_mv(st.slow_over[c], range_multiplier[c]);
      next_st.slow_under_flag[c] = slow_level[c] < limit_mv(st.slow_under[c], range_multiplier[c]);
      next_st.cutoff_out[c]      = st.cutoff[c][2:0];
    end

    if (st.tick_cnt == TICK_W'(LPF_TICK_CYCLES - 1))
    begin
      next_st.tick_cnt = '0;
      next_st.lpf_tick = 1'b1;
    end
    else
    begin
      next_st.tick_cnt = st.tick_cnt + TICK_W'(1);
    end

    // The delay restarts if manual reset is set again, so the output never releases early.
    case (st.rst_state)
      RST_IDLE:
      begin
        if (st.control[CTRL_MANRST])
        begin
          next_st.rst_state = RST_HELD;
        end
      end
      RST_HELD:
      begin
        if (!st.control[CTRL_MANRST])
        begin
          next_st.rst_state = RST_DELAY;
          next_st.delay_cnt = RST_CNT_W'(RESET_DELAY_CYCLES[st.control[CTRL_DELAY_LSB +: 3]] - 1);
        end
      end
      RST_DELAY:
      begin
        if (st.control[CTRL_MANRST])
        begin
          next_st.rst_state = RST_HELD;
        end
        else if (st.delay_cnt == '0)
        begin
          next_st.rst_state = RST_IDLE;
        end
        else
        begin
          next_st.delay_cnt = st.delay_cnt - RST_CNT_W'(1);
        end
      end
      default:
      begin
        next_st.rst_state = RST_IDLE;
      end
    endcase
    next_st.rst_out_n = (next_st.rst_state == RST_IDLE);
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st            <= '0;
      st.fast_under <= {2{UNDER_RESET}};
      st.slow_under <= {2{UNDER_RESET}};
      st.fast_over  <= {2{OVER_RESET}};
      st.slow_over  <= {2{OVER_RESET}};
      st.debounce   <= {2{DEBOUNCE_RESET}};
      st.cutoff     <= {2{CUTOFF_RESET}};
      st.cutoff_out <= {2{CUTOFF_RESET[2:0]}};
      st.control    <= CONTROL_RESET;
      st.rst_state  <= RST_IDLE;
      st.rst_out_n  <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  for (genvar c = 0; c < 2; c++)
  begin : g_chan
    fast_fault_debounce #(
      .UNIT_CYCLES (DEBOUNCE_LONGEST_CYCLES >> DEB_CODE_CAP)
    ) u_over_deb (
      .clk_sys  (clk_sys),
      .arst_n   (arst_n),
      .raw      (st.fast_over_raw[c]),
      .code     (st.debounce[c][DEB_OVER_LSB +: 4]),
      .filtered (fast_over_db[c])
    );
    fast_fault_debounce #(
      .UNIT_CYCLES (DEBOUNCE_LONGEST_CYCLES >> DEB_CODE_CAP)
    ) u_under_deb (
      .clk_sys  (clk_sys),
      .arst_n   (arst_n),
      .raw      (st.fast_under_raw[c]),
      .code     (st.debounce[c][DEB_UNDER_LSB +: 4]),
      .filtered (fast_under_db[c])
    );
    slow_path_lowpass u_lowpass (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .tick    (st.lpf_tick),
      .sample  (slow_sample_mv[c]),
      .cutoff  (st.cutoff[c][2:0]),
      .level   (slow_level[c])
    );
  end

  assign reg_rdata        = st.rdata;
  assign fast_over_fault  = fast_over_db;
  assign fast_under_fault = fast_under_db;
  assign slow_over_fault  = st.slow_over_flag;
  assign slow_under_fault = st.slow_under_flag;
  assign slow_cutoff_code = st.cutoff_out;
  assign selftest_start   = st.selftest_pulse;
  assign reset_out_n      = st.rst_out_n;

  over_reset_a: assert property (@(posedge clk_sys) $rose(arst_n) |->
    st.fast_over == {2{OVER_RESET}} && st.slow_over == {2{OVER_RESET}})
    else $error("Overvoltage limits did not leave reset at all ones.");

  under_reset_a: assert property (@(posedge clk_sys) $rose(arst_n) |->
    st.fast_under == {2{UNDER_RESET}} && st.slow_under == {2{UNDER_RESET}})
    else $error("Undervoltage limits did not leave reset at zero.");

  control_reset_a: assert property (@(posedge clk_sys) $rose(arst_n) |->
    st.control == CONTROL_RESET && st.cutoff == {2{CUTOFF_RESET}})
    else $error("Control or cutoff register has the wrong reset value.");

  cutoff_readonly_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    reg_read && reg_addr == ADDR_CH8_CUTOFF |=> reg_rdata[7:3] == CUTOFF_RESET[7:3])
    else $error("Read-only cutoff bits changed.");

  selftest_entry_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    reg_write && reg_addr == ADDR_CONTROL && reg_wdata[CTRL_SELFTEST] |=> selftest_start ##1 !selftest_start)
    else $error("Self-test start was not a single pulse after the write.");

  manual_reset_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    st.control[CTRL_MANRST] |=> !reset_out_n)
    else $error("Manual reset bit did not assert the reset output.");

  reset_delay_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(reset_out_n) |-> $past(st.rst_state) == RST_DELAY && $past(st.delay_cnt) == '0)
    else $error("Reset output released before the delay ran out.");

  fast_limit_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !range_multiplier[0] && st.fast_under[0] == UNDER_RESET && fast_sample_mv[0] < BASE_1X_MV
    |=> st.fast_under_raw[0])
    else $error("Sample below the lowest 1x limit was not flagged.");

  slow_compare_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !range_multiplier[1] && slow_level[1] <= BASE_1X_MV + MV_W'(st.slow_over[1]) * STEP_1X_MV
    |=> !st.slow_over_flag[1])
    else $error("Slow overvoltage flag set at or below the limit.");

  slow_under_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !range_multiplier[1] && slow_level[1] < BASE_1X_MV + MV_W'(st.slow_under[1]) * STEP_1X_MV
    |=> st.slow_under_flag[1])
    else $error("Slow undervoltage flag missed a level below the limit.");

endmodule : supervisor_channel_config_regs

// [tb/supervisor_host_model.sv]
// Host model that drives the register port of the supervisor bank.
module supervisor_host_model
  import supervisor_cfg_pkg::*;
(
  // Clock
  input  wire logic       clk_sys,
  // Register port
  output logic            reg_write,
  output logic            reg_read,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] exp_q[$];
  initial
  begin
    reg_write = 1'b0;
    reg_read  = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // Callers keep debounce codes at 2 or above and cutoff codes in 2 to 6.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_write = w;
    reg_read  = ~w;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_write = 1'b0;
    reg_read  = 1'b0;
    // Released lines are inverted so a stale value is never mistaken for a live one.
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : acc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    acc(1'b0, a, 8'h00);
  endtask : rd
endmodule : supervisor_host_model

// [tb/supervisor_channel_config_regs_tb.sv]
// Self-checking testbench for the channel 7 and 8 supervisor configuration bank.
module supervisor_channel_config_regs_tb
  import supervisor_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned DLY [8] = '{2, 4, 6, 8, 10, 12, 14, 16};
  localparam logic [7:0] ADR [13] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h90, 8'h91, 8'h92,
    8'h93, 8'h94, 8'h95, 8'h9F};
  localparam logic [7:0] RST [13] = '{8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h14, 8'h00, 8'hFF, 8'h00,
    8'hFF, 8'h00, 8'h14, 8'h02};
  logic                 clk_sys, arst_n, reg_write, reg_read, selftest_start, reset_out_n, rd_seen;
  logic [7:0]           reg_addr, reg_wdata, reg_rdata, d;
  logic [1:0]           range_multiplier, fast_over_fault, fast_under_fault, slow_over_fault, slow_under_fault;
  logic [1:0][MV_W-1:0] fast_sample_mv, slow_sample_mv;
  logic [1:0][2:0]      slow_cutoff_code;
  int                   n_fail, total_checks, k, seed_ret;

  supervisor_host_model u_host (.clk_sys(clk_sys), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  supervisor_channel_config_regs #(.DEBOUNCE_LONGEST_CYCLES(1024), .RESET_DELAY_CYCLES(DLY)) u_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .range_multiplier(range_multiplier),
    .fast_sample_mv(fast_sample_mv), .slow_sample_mv(slow_sample_mv), .fast_over_fault(fast_over_fault),
    .fast_under_fault(fast_under_fault), .slow_over_fault(slow_over_fault),
    .slow_under_fault(slow_under_fault), .slow_cutoff_code(slow_cutoff_code),
    .selftest_start(selftest_start), .reset_out_n(reset_out_n));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  // Idle at the limit itself, then a glitch one cycle short of the debounce time, then a real crossing.
  task automatic fault_time(input int ch, input logic ov, input logic [12:0] idle, input logic [12:0] hit);
    fast_sample_mv[ch] = idle;
    repeat (20) @(negedge clk_sys);
    chk({7'h00, ov ? fast_over_fault[ch] : fast_under_fault[ch]}, 8'h00);
    fast_sample_mv[ch] = hit;
    repeat (3) @(negedge clk_sys);
    fast_sample_mv[ch] = idle;
    repeat (10) @(negedge clk_sys);
    chk({7'h00, ov ? fast_over_fault[ch] : fast_under_fault[ch]}, 8'h00);
    fast_sample_mv[ch] = hit;
    k = 0;
    while ((ov ? fast_over_fault[ch] : fast_under_fault[ch]) !== 1'b1 && k < 50)
    begin
      @(negedge clk_sys);
      k++;
    end
    chk(8'(k), 8'h05);
  endtask : fault_time

  always @(posedge clk_sys) rd_seen <= reg_read;
  always @(negedge clk_sys)
  begin
    if (rd_seen === 1'b1 && u_host.exp_q.size() > 0)
      chk(reg_rdata, u_host.exp_q.pop_front());
  end

  initial
  begin
    clk_sys = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
  end

  initial
  begin
    #(CLK_PERIOD_NS * 5000);
    n_fail++;
    wrap_up();
  end

  initial
  begin
    arst_n = 1'b0;
    range_multiplier = 2'b00;
    fast_sample_mv = {13'h01F4, 13'h01F4};
    slow_sample_mv = {13'h01F4, 13'h01F4};
    n_fail = 0;
    total_checks = 0;
    seed_ret = $urandom(95);
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    arst_n = 1'b1;
    chk({5'h00, slow_cutoff_code[0]}, {5'h00, CUT_1KHZ});
    chk({7'h00, reset_out_n}, 8'h01);
    for (int i = 0; i < 13; i++)
      u_host.rd(ADR[i], RST[i]);
    u_host.rd(8'h86, UNMAPPED_READ);
    chk({6'h00, slow_under_fault}, 8'h03);
    chk({6'h00, slow_over_fault}, 8'h00);
    fast_sample_mv[0] = 13'h00C7;
    repeat (3) @(negedge clk_sys);
    chk({7'h00, fast_under_fault[0]}, 8'h01);
    $display("test reset values done");
    for (int i = 0; i < 12; i++)
    begin
      d = 8'($urandom);
      slow_sample_mv[i / 6] = 13'($urandom % 1500);
      if (ADR[i][3:0] == 4'h4)
        d = d | 8'h22;
      if (ADR[i][3:0] == 4'h5)
        d = {5'h1F, 3'(2 + $urandom % 5)};
      u_host.wr(ADR[i], d);
      u_host.rd(ADR[i], (ADR[i][3:0] == 4'h5) ? (8'h10 | (d & CUTOFF_WMASK)) : d);
    end
    $display("test read write done");
    for (int c = 2; c < 7; c++)
    begin
      u_host.wr(ADDR_CH8_CUTOFF, 8'(c));
      @(negedge clk_sys);
      chk({5'h00, slow_cutoff_code[1]}, 8'(c));
    end
    $display("test cutoff codes done");
    u_host.wr(ADDR_CONTROL, 8'hDA);
    k = 0;
    repeat (4)
    begin
      if (selftest_start === 1'b1)
        k++;
      @(negedge clk_sys);
    end
    chk(8'(k), 8'h01);
    u_host.rd(ADDR_CONTROL, 8'hC2);
    u_host.wr(ADDR_CONTROL, 8'h23);
    repeat (2) @(negedge clk_sys);
    chk({7'h00, reset_out_n}, 8'h00);
    u_host.wr(ADDR_CONTROL, 8'h03);
    repeat (DLY[3]) @(negedge clk_sys);
    chk({7'h00, reset_out_n}, 8'h00);
    repeat (6) @(negedge clk_sys);
    chk({7'h00, reset_out_n}, 8'h01);
    $display("test self-test and manual reset done");
    u_host.wr(ADDR_CH7_FAST_UNDER, 8'h00);
    u_host.wr(ADDR_CH7_FAST_OVER, 8'h10);
    u_host.wr(ADDR_CH7_DEBOUNCE, 8'h22);
    fault_time(0, 1'b1, 13'h0118, 13'h0119);
    range_multiplier = 2'b10;
    u_host.wr(ADDR_CH8_FAST_UNDER, 8'h10);
    u_host.wr(ADDR_CH8_FAST_OVER, 8'hFF);
    u_host.wr(ADDR_CH8_DEBOUNCE, 8'h22);
    fault_time(1, 1'b0, 13'h0460, 13'h045F);
    $display("test fault debounce done");
    wrap_up();
  end
endmodule : supervisor_channel_config_regs_tb
